// ---- inc/sdram_consts.svh ----
// Timing, encoding and field constants for the DRAM command link
`ifndef SDRAM_CONSTS_SVH
`define SDRAM_CONSTS_SVH

`define CLK_NS       4
`define PRECH_NS     18
`define ACT_NS       18
`define RECOV_NS     12
`define SREXIT_NS    120
`define CYC(ns)      (((ns) + `CLK_NS - 1) / `CLK_NS)
`define PRECH_CYC    `CYC(`PRECH_NS)
`define ACT_CYC      `CYC(`ACT_NS)
`define RECOV_CYC    `CYC(`RECOV_NS)
`define SREXIT_CYC   `CYC(`SREXIT_NS)

// Strobes packed as {select, row, column, write}, all active low
`define ENC_LMR      4'h0
`define ENC_REF      4'h1
`define ENC_PRE      4'h2
`define ENC_ACT      4'h3
`define ENC_WRITE    4'h4
`define ENC_READ     4'h5
`define ENC_TERM     4'h6
`define ENC_NOP      4'h7

`define AP_BIT       10
`define COL_MSB      7
`define BURST_LAST   2'h3
`define MASK_ON      2'h3
`define MASK_OFF     2'h0
`define MASK_LEAD    2'h1
`define MASK_LEAD_AP 2'h2
`define MIN_NOPS     2'h2

`endif

// ---- inc/sdram_pkg.sv ----
// Shared types for both link ends; command decoding for the memory end
`include "sdram_consts.svh"

package sdram_pkg;

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
    CMD_PRE, CMD_REF, CMD_LMR, CMD_TERM
  } cmd_t;

  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_RECOVER, BK_PRECH
  } bank_st_t;

  typedef enum logic [2:0] {
    PW_RUN, PW_DOWN, PW_SELF, PW_EXIT, PW_SUSP, PW_DEEP
  } pwr_t;

  typedef enum logic [3:0] {
    OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REFRESH,
    OP_SLEEP, OP_SELF, OP_DEEP, OP_WAKE, OP_TERM
  } op_t;

  function automatic cmd_t decode(input logic [3:0] s);
    cmd_t c;
    c = CMD_INHIBIT;
    case (s)
      `ENC_LMR:   c = CMD_LMR;
      `ENC_REF:   c = CMD_REF;
      `ENC_PRE:   c = CMD_PRE;
      `ENC_ACT:   c = CMD_ACT;
      `ENC_WRITE: c = CMD_WRITE;
      `ENC_READ:  c = CMD_READ;
      `ENC_TERM:  c = CMD_TERM;
      `ENC_NOP:   c = CMD_NOP;
      default:    c = CMD_INHIBIT;
    endcase
    return c;
  endfunction

endpackage

// ---- inc/sdram_link_if.sv ----
// Command, address and data link between controller and memory
`timescale 1ns/1ps
interface sdram_link_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        cke;
  logic [1:0]  ba;
  logic [11:0] addr;
  logic [1:0]  dqm;
  logic [15:0] h_dq;
  logic        h_dq_oe;
  logic [15:0] d_dq;
  logic        d_dq_oe;
  logic [15:0] dq;

  // Shared data wire; memory wins if both drive
  assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : 16'h0000);

  modport dev (
    input  cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq,
    output d_dq, d_dq_oe
  );
  modport host (
    output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, h_dq, h_dq_oe,
    input  dq
  );
endinterface

// ---- rtl/bank_track.sv ----
// Per-bank state tracker shared by memory and controller
`timescale 1ns/1ps
module bank_track
  import sdram_pkg::*;
(
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic act,
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic pre,
  input  wire logic ap,
  input  wire logic burst_end,
  output bank_st_t  st_q
);

  bank_st_t   st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
    case (st_q)
      BK_IDLE: begin
        if (act) begin
          st_d  = BK_ACTING;
          cnt_d = 4'(`ACT_CYC - 1);
        end
      end
      BK_ACTING: begin
        if (cnt_q == 4'h0) st_d = BK_ACTIVE;
      end
      BK_ACTIVE, BK_READ, BK_WRITE: begin
        if (pre) begin
          st_d  = BK_PRECH;
          cnt_d = 4'(`PRECH_CYC - 1);
        end else if (rd || wr) begin
          st_d = ap ? (rd ? BK_READ_AP : BK_WRITE_AP)
                    : (rd ? BK_READ : BK_WRITE);
        end else if (burst_end && st_q != BK_ACTIVE) begin
          st_d = BK_ACTIVE;
        end
      end
      BK_READ_AP: begin
        if (burst_end) begin
          st_d  = BK_PRECH;
          cnt_d = 4'(`PRECH_CYC - 1);
        end
      end
      BK_WRITE_AP: begin
        if (burst_end) begin
          st_d  = BK_RECOVER;
          cnt_d = 4'(`RECOV_CYC - 1);
        end
      end
      BK_RECOVER: begin
        if (cnt_q == 4'h0) begin
          st_d  = BK_PRECH;
          cnt_d = 4'(`PRECH_CYC - 1);
        end
      end
      BK_PRECH: begin
        if (cnt_q == 4'h0) st_d = BK_IDLE;
      end
      default: st_d = BK_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q  <= BK_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ---- rtl/sdram_dev_end.sv ----
// Memory end: command acceptance, bank interleave and power states
`timescale 1ns/1ps
module sdram_dev_end
  import sdram_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  sdram_link_if.dev        LINK,
  input  wire logic        CL3,
  output logic             MEM_WE,
  output logic [1:0]       MEM_WBANK,
  output logic [7:0]       MEM_WCOL,
  output logic [15:0]      MEM_WDATA,
  output logic [1:0]       MEM_WMASK,
  output logic [1:0]       MEM_RBANK,
  output logic [7:0]       MEM_RCOL,
  input  wire logic [15:0] MEM_RDATA,
  output pwr_t             POWER,
  output bank_st_t         BANK_ST [4],
  output logic             ILLEGAL
);

  // ******************************************************
  // Command decode
  // ******************************************************
  cmd_t       cmd;
  pwr_t       pwr_q;
  pwr_t       pwr_d;
  logic       cke_prev_q;
  logic [7:0] xsr_q;
  logic [1:0] nops_q;
  logic       nopish;
  logic       run;
  logic       gate_fall;
  logic       all_idle;
  logic       is_act;
  logic       is_rd;
  logic       is_wr;
  logic       is_pre;
  logic       pre_all;
  logic       is_refl;
  bank_st_t   tgt;
  logic       tgt_open;

  assign cmd = decode({LINK.cs_n, LINK.ras_n,
                       LINK.cas_n, LINK.we_n});
  assign nopish = (cmd == CMD_INHIBIT) || (cmd == CMD_NOP);
  assign run = (pwr_q == PW_RUN) && cke_prev_q && LINK.cke;
  assign gate_fall = (pwr_q == PW_RUN) && cke_prev_q && !LINK.cke;
  assign all_idle = (BANK_ST[0] == BK_IDLE) && (BANK_ST[1] == BK_IDLE)
                 && (BANK_ST[2] == BK_IDLE) && (BANK_ST[3] == BK_IDLE);
  assign is_act = run && (cmd == CMD_ACT);
  assign is_rd = run && (cmd == CMD_READ);
  assign is_wr = run && (cmd == CMD_WRITE);
  assign is_pre = run && (cmd == CMD_PRE);
  assign pre_all = is_pre && LINK.addr[`AP_BIT];
  assign is_refl = run && ((cmd == CMD_REF) || (cmd == CMD_LMR));
  assign tgt = BANK_ST[LINK.ba];
  assign tgt_open = (tgt == BK_ACTIVE) || (tgt == BK_READ)
                 || (tgt == BK_WRITE);

  // ******************************************************
  // Burst engine
  // ******************************************************
  logic       bur_on_q;
  logic       bur_wr_q;
  logic [1:0] bur_bank_q;
  logic [7:0] bur_col_q;
  logic [1:0] bur_left_q;
  logic       new_burst;
  logic       term;
  logic       pre_cut;
  logic       bur_stop;
  logic       cont;
  logic       suspend;
  logic [7:0] next_col;
  logic       wr_word;
  logic       rd_word;

  assign new_burst = is_rd || is_wr;
  // Terminate only ever reaches the bank holding the burst
  assign term = run && (cmd == CMD_TERM) && bur_on_q;
  // Precharge to another bank leaves the burst alone
  assign pre_cut = is_pre && (pre_all || LINK.ba == bur_bank_q);
  assign suspend = (pwr_q == PW_SUSP);
  assign bur_stop = bur_on_q && !suspend
                 && (new_burst || term || pre_cut || bur_left_q == 2'h0);
  assign cont = bur_on_q && !suspend && !bur_stop;
  // Sequential order wrapping inside a block of four columns
  assign next_col = {bur_col_q[`COL_MSB:2], bur_col_q[1:0] + 2'h1};
  assign wr_word = is_wr || (cont && bur_wr_q);
  assign rd_word = is_rd || (cont && !bur_wr_q);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bur_on_q   <= 1'b0;
      bur_wr_q   <= 1'b0;
      bur_bank_q <= 2'h0;
      bur_col_q  <= 8'h00;
      bur_left_q <= 2'h0;
    end else if (new_burst) begin
      bur_on_q   <= 1'b1;
      bur_wr_q   <= is_wr;
      bur_bank_q <= LINK.ba;
      bur_col_q  <= LINK.addr[`COL_MSB:0];
      bur_left_q <= `BURST_LAST;
    end else if (bur_stop) begin
      bur_on_q <= 1'b0;
    end else if (cont) begin
      bur_col_q  <= next_col;
      bur_left_q <= bur_left_q - 2'h1;
    end
  end

  // ******************************************************
  // Bank trackers
  // ******************************************************
  for (genvar i = 0; i < 4; i++) begin : g_bank
    wire logic hit = (LINK.ba == 2'(i));
    wire logic own = bur_on_q && (bur_bank_q == 2'(i));
    // A cut burst ends its bank here, which also starts
    // the concurrent auto precharge
    bank_track u_trk (
      .CLK       (CLK),
      .SYS_RST   (SYS_RST),
      .act       (is_act && hit),
      .rd        (is_rd && hit),
      .wr        (is_wr && hit),
      .pre       (is_pre && (hit || pre_all)),
      .ap        (LINK.addr[`AP_BIT]),
      .burst_end (own && bur_stop),
      .st_q      (BANK_ST[i])
    );
  end

  // ******************************************************
  // Write path
  // ******************************************************
  // The command edge takes the new bank's first word, so the
  // interrupted bank's last word is the one before it
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MEM_WE    <= 1'b0;
      MEM_WBANK <= 2'h0;
      MEM_WCOL  <= 8'h00;
      MEM_WDATA <= 16'h0000;
      MEM_WMASK <= `MASK_OFF;
    end else begin
      MEM_WE <= wr_word;
      if (wr_word) begin
        MEM_WBANK <= is_wr ? LINK.ba : bur_bank_q;
        MEM_WCOL  <= is_wr ? LINK.addr[`COL_MSB:0] : next_col;
        MEM_WDATA <= LINK.dq;
        MEM_WMASK <= LINK.dqm;
      end
    end
  end

  // ******************************************************
  // Read path
  // ******************************************************
  logic        tok_v_q;
  logic        v1_q;
  logic [15:0] d1_q;
  logic        out_v_q;
  logic [15:0] out_q;
  logic        mask_q;

  // Mask sampled now blanks the word driven two edges later
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tok_v_q   <= 1'b0;
      MEM_RBANK <= 2'h0;
      MEM_RCOL  <= 8'h00;
      v1_q      <= 1'b0;
      d1_q      <= 16'h0000;
      out_v_q   <= 1'b0;
      out_q     <= 16'h0000;
      mask_q    <= 1'b0;
    end else begin
      tok_v_q <= rd_word;
      if (rd_word) begin
        MEM_RBANK <= is_rd ? LINK.ba : bur_bank_q;
        MEM_RCOL  <= is_rd ? LINK.addr[`COL_MSB:0] : next_col;
      end
      mask_q  <= (LINK.dqm != `MASK_OFF);
      v1_q    <= tok_v_q && !is_wr;
      d1_q    <= MEM_RDATA;
      out_v_q <= !is_wr && !mask_q
              && (CL3 ? v1_q : tok_v_q);
      out_q   <= CL3 ? d1_q : MEM_RDATA;
    end
  end

  assign LINK.d_dq = out_q;
  assign LINK.d_dq_oe = out_v_q;

  // ******************************************************
  // Clock gate power states
  // ******************************************************
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PW_RUN: begin
        if (gate_fall && all_idle && nopish)
          pwr_d = PW_DOWN;
        else if (gate_fall && all_idle && cmd == CMD_REF)
          pwr_d = PW_SELF;
        else if (gate_fall && all_idle && cmd == CMD_TERM)
          pwr_d = PW_DEEP;
        else if (gate_fall && bur_on_q && !nopish)
          pwr_d = PW_SUSP;
      end
      // Low-low holds; a rising gate decides the exit
      PW_DOWN: if (LINK.cke && nopish) pwr_d = PW_RUN;
      PW_SELF: if (LINK.cke && nopish) pwr_d = PW_EXIT;
      PW_EXIT: if (xsr_q == 8'h00) pwr_d = PW_RUN;
      PW_SUSP: if (LINK.cke) pwr_d = PW_RUN;
      PW_DEEP: if (LINK.cke) pwr_d = PW_RUN;
      default: pwr_d = PW_RUN;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwr_q      <= PW_RUN;
      cke_prev_q <= 1'b0;
      xsr_q      <= 8'h00;
      nops_q     <= 2'h0;
    end else begin
      pwr_q      <= pwr_d;
      cke_prev_q <= LINK.cke;
      if (pwr_q != PW_EXIT) begin
        xsr_q  <= 8'(`SREXIT_CYC - 1);
        nops_q <= 2'h0;
      end else begin
        xsr_q <= xsr_q - 8'h01;
        if (cmd == CMD_NOP && nops_q != `MIN_NOPS)
          nops_q <= nops_q + 2'h1;
      end
    end
  end

  assign POWER = pwr_q;

  // ******************************************************
  // Misuse flag
  // ******************************************************
  // Flags the controller's mistakes; the flag blocks nothing, but commands in PW_EXIT are ignored
  logic bad;
  assign bad = (is_act && tgt != BK_IDLE)
            || (new_burst && !tgt_open)
            || (is_refl && !all_idle)
            || (pwr_q == PW_EXIT && !nopish)
            || (pwr_q == PW_EXIT && xsr_q == 8'h00
                && nops_q != `MIN_NOPS);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ILLEGAL <= 1'b0;
    end else begin
      ILLEGAL <= bad;
    end
  end

endmodule

// ---- rtl/sdram_host_end.sv ----
// Controller end: issues legal commands and power sequences
`timescale 1ns/1ps
module sdram_host_end
  import sdram_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  sdram_link_if.host       LINK,
  input  wire logic        CL3,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  op_t              REQ_OP,
  input  wire logic [1:0]  REQ_BANK,
  input  wire logic [11:0] REQ_ADDR,
  input  wire logic [15:0] WR_DATA,
  output logic             WR_TAKE,
  output logic [15:0]      RD_DATA,
  output logic             RD_VALID,
  output pwr_t             POWER
);

  // ******************************************************
  // Legality against own bank view
  // ******************************************************
  bank_st_t   bst [4];
  bank_st_t   tgt;
  logic       all_idle;
  logic       open_b;
  logic       reading;
  logic [1:0] lead;
  logic       mask_ok;
  logic       ok;
  logic       go;
  logic [1:0] mask_cnt_q;
  logic       hb_on_q;
  logic       hb_wr_q;
  logic       hb_ap_q;
  logic [1:0] hb_bank_q;
  logic [1:0] hb_left_q;
  pwr_t       pwr_q;
  logic [7:0] xsr_q;

  assign tgt = bst[REQ_BANK];
  assign all_idle = (bst[0] == BK_IDLE) && (bst[1] == BK_IDLE)
                 && (bst[2] == BK_IDLE) && (bst[3] == BK_IDLE);
  assign open_b = (tgt == BK_ACTIVE) || (tgt == BK_READ)
               || (tgt == BK_WRITE);
  assign reading = hb_on_q && !hb_wr_q;
  assign lead = hb_ap_q ? `MASK_LEAD_AP : `MASK_LEAD;
  assign mask_ok = !reading || (mask_cnt_q >= lead);

  always_comb begin
    ok = 1'b0;
    case (REQ_OP)
      OP_ACT:     ok = (tgt == BK_IDLE);
      OP_READ:    ok = open_b;
      OP_WRITE:   ok = open_b && mask_ok;
      OP_PRE:     ok = open_b || (tgt == BK_IDLE);
      OP_REFRESH: ok = all_idle;
      OP_SLEEP:   ok = all_idle;
      OP_SELF:    ok = all_idle;
      OP_DEEP:    ok = all_idle;
      OP_TERM:    ok = hb_on_q;
      default:    ok = 1'b0;
    endcase
    if (pwr_q != PW_RUN) ok = (REQ_OP == OP_WAKE)
                           && (pwr_q != PW_EXIT);
  end

  assign REQ_READY = ok;
  assign go = REQ_VALID && ok;

  // ******************************************************
  // Burst mirror
  // ******************************************************
  logic go_act;
  logic go_rd;
  logic go_wr;
  logic go_pre;
  logic stop;
  logic cont;
  logic rd_word;
  logic mask_wait;

  assign go_act = go && REQ_OP == OP_ACT;
  assign go_rd = go && REQ_OP == OP_READ;
  assign go_wr = go && REQ_OP == OP_WRITE;
  assign go_pre = go && REQ_OP == OP_PRE;
  assign stop = hb_on_q && (go_rd || go_wr || (go && REQ_OP == OP_TERM)
             || (go_pre && (REQ_ADDR[`AP_BIT] || REQ_BANK == hb_bank_q))
             || hb_left_q == 2'h0);
  assign cont = hb_on_q && !stop;
  assign WR_TAKE = go_wr || (cont && hb_wr_q);
  assign rd_word = go_rd || (cont && !hb_wr_q);
  assign mask_wait = REQ_VALID && REQ_OP == OP_WRITE && open_b
                  && reading && !mask_ok;

  for (genvar i = 0; i < 4; i++) begin : g_bank
    wire logic hit = (REQ_BANK == 2'(i));
    bank_track u_trk (
      .CLK       (CLK),
      .SYS_RST   (SYS_RST),
      .act       (go_act && hit),
      .rd        (go_rd && hit),
      .wr        (go_wr && hit),
      .pre       (go_pre && (hit || REQ_ADDR[`AP_BIT])),
      .ap        (REQ_ADDR[`AP_BIT]),
      .burst_end (stop && hb_bank_q == 2'(i)),
      .st_q      (bst[i])
    );
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hb_on_q   <= 1'b0;
      hb_wr_q   <= 1'b0;
      hb_ap_q   <= 1'b0;
      hb_bank_q <= 2'h0;
      hb_left_q <= 2'h0;
    end else if (go_rd || go_wr) begin
      hb_on_q   <= 1'b1;
      hb_wr_q   <= go_wr;
      hb_ap_q   <= REQ_ADDR[`AP_BIT];
      hb_bank_q <= REQ_BANK;
      hb_left_q <= `BURST_LAST;
    end else if (stop) begin
      hb_on_q <= 1'b0;
    end else if (cont) begin
      hb_left_q <= hb_left_q - 2'h1;
    end
  end

  // ******************************************************
  // Link drive and power sequencing
  // ******************************************************
  logic [3:0] enc_d;
  logic [3:0] rv_q;

  always_comb begin
    enc_d = `ENC_NOP;
    if (go) begin
      case (REQ_OP)
        OP_ACT:     enc_d = `ENC_ACT;
        OP_READ:    enc_d = `ENC_READ;
        OP_WRITE:   enc_d = `ENC_WRITE;
        OP_PRE:     enc_d = `ENC_PRE;
        OP_REFRESH: enc_d = `ENC_REF;
        OP_SELF:    enc_d = `ENC_REF;
        OP_DEEP:    enc_d = `ENC_TERM;
        OP_TERM:    enc_d = `ENC_TERM;
        default:    enc_d = `ENC_NOP;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= `ENC_NOP;
      LINK.cke     <= 1'b1;
      LINK.ba      <= 2'h0;
      LINK.addr    <= 12'h000;
      LINK.dqm     <= `MASK_OFF;
      LINK.h_dq    <= 16'h0000;
      LINK.h_dq_oe <= 1'b0;
      mask_cnt_q   <= 2'h0;
      pwr_q        <= PW_RUN;
      xsr_q        <= 8'h00;
    end else begin
      {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= enc_d;
      if (go) begin
        LINK.ba   <= REQ_BANK;
        LINK.addr <= REQ_ADDR;
      end
      // Mask leads a write that cuts a read
      LINK.dqm     <= mask_wait ? `MASK_ON : `MASK_OFF;
      mask_cnt_q   <= (mask_wait && mask_cnt_q != `MASK_ON)
                      ? mask_cnt_q + 2'h1 : (mask_wait ? mask_cnt_q : 2'h0);
      LINK.h_dq_oe <= WR_TAKE;
      if (WR_TAKE) LINK.h_dq <= WR_DATA;
      if (go && (REQ_OP == OP_SLEEP || REQ_OP == OP_SELF
                 || REQ_OP == OP_DEEP))
        LINK.cke <= 1'b0;
      else if (go && REQ_OP == OP_WAKE)
        LINK.cke <= 1'b1;
      case (pwr_q)
        PW_RUN: begin
          if (go && REQ_OP == OP_SLEEP) pwr_q <= PW_DOWN;
          else if (go && REQ_OP == OP_SELF) pwr_q <= PW_SELF;
          else if (go && REQ_OP == OP_DEEP) pwr_q <= PW_DEEP;
        end
        // Only no-ops go out while the exit time runs
        PW_SELF: begin
          if (go) begin
            pwr_q <= PW_EXIT;
            xsr_q <= 8'(`SREXIT_CYC - 1);
          end
        end
        PW_EXIT: begin
          xsr_q <= xsr_q - 8'h01;
          if (xsr_q == 8'h00) pwr_q <= PW_RUN;
        end
        default: if (go) pwr_q <= PW_RUN;
      endcase
    end
  end

  assign POWER = pwr_q;

  // ******************************************************
  // Read capture
  // ******************************************************
  // A write issue drops read words still in flight
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rv_q     <= 4'h0;
      RD_VALID <= 1'b0;
      RD_DATA  <= 16'h0000;
    end else begin
      rv_q     <= go_wr ? 4'h0 : {rv_q[2:0], rd_word};
      RD_VALID <= !go_wr && (CL3 ? rv_q[3] : rv_q[2]);
      RD_DATA  <= LINK.dq;
    end
  end

endmodule

// ---- tb/sdram_link_asserts.sv ----
// Link checker between controller end and memory end
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_link_asserts (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       CL3,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       cke,
  input wire logic [1:0] dqm,
  input wire logic       h_dq_oe,
  input wire logic       d_dq_oe
);
  wire logic [3:0] cmd  = {cs_n, ras_n, cas_n, we_n};
  wire logic       idle = cs_n || cmd == `ENC_NOP;
  wire logic       rd_c = cke && cmd == `ENC_READ;
  wire logic       wr_c = cke && cmd == `ENC_WRITE;
  logic            cke_q;
  logic            self_q;
  // Remembers self refresh entry until gate is high twice
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cke_q  <= 1'b1;
      self_q <= 1'b0;
    end else begin
      cke_q  <= cke;
      self_q <= (cke_q && !cke && cmd == `ENC_REF) || (self_q && !cke_q);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  bus_owner_a: assert property (!(d_dq_oe && h_dq_oe))
    else $error("both ends drive data");
  lat_two_a: assert property (
    rd_c && !CL3 && dqm == `MASK_OFF ##1 !wr_c |=> d_dq_oe)
    else $error("read data late at latency two");
  lat_three_a: assert property (
    rd_c && CL3 ##1 (dqm == `MASK_OFF && !wr_c) ##1 !wr_c |=> d_dq_oe)
    else $error("read data late at latency three");
  gate_fall_a: assert property ($fell(cke) |->
    idle || cmd == `ENC_REF || cmd == `ENC_TERM)
    else $error("bad command at gate fall");
  gate_rise_a: assert property ($rose(cke) |-> idle)
    else $error("bad command at gate rise");
  self_exit_a: assert property ($rose(cke) && self_q |-> idle [*8])
    else $error("command during self refresh exit");
  refresh_quiet_a: assert property (cke && cmd == `ENC_REF |->
    !d_dq_oe && !h_dq_oe) else $error("refresh during burst");
  write_drive_a: assert property (wr_c |-> h_dq_oe)
    else $error("write without data");
  read_cut_a: assert property (rd_c |-> !h_dq_oe)
    else $error("write data at read");
  sleep_quiet_a: assert property (!cke && !$past(cke) |-> !d_dq_oe
    && !h_dq_oe) else $error("data while gated");
  cover property (wr_c ##[1:3] rd_c);
  cover property (rd_c ##[2:3] d_dq_oe);
  cover property ($rose(cke) && self_q);
endmodule

// ---- tb/tb_top.sv ----
// Bench joining controller end and memory end
`timescale 1ns/1ps
module tb_top;
  import sdram_pkg::*;
  logic        CLK = 0;
  logic        SYS_RST = 1;
  logic        cl3 = 0;
  logic        req_valid = 0;
  logic        req_ready, wr_take, rd_valid, mem_we, illegal;
  op_t         req_op = OP_ACT;
  logic [1:0]  req_bank = 2'h0, mem_rbank;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] wr_data = 16'h0000, rd_data, mem_wdata;
  logic [7:0]  mem_rcol;
  pwr_t        dev_power, host_power;
  logic [15:0] rq[$], wq[$];
  int          err_count = 0;
  int          checked = 0;
  op_t         sl [3] = '{OP_SLEEP, OP_SELF, OP_DEEP};
  pwr_t        pw [3] = '{PW_DOWN, PW_SELF, PW_DEEP};
  always #2 CLK = ~CLK;
  sdram_link_if sdram_link_if_inst ();
  sdram_dev_end sdram_dev_end_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .LINK(sdram_link_if_inst.dev), .CL3(cl3), .MEM_WE(mem_we),
    .MEM_WBANK(), .MEM_WCOL(), .MEM_WDATA(mem_wdata), .MEM_WMASK(),
    .MEM_RBANK(mem_rbank), .MEM_RCOL(mem_rcol),
    .MEM_RDATA({mem_rbank, 6'h15, mem_rcol}), .POWER(dev_power),
    .BANK_ST(), .ILLEGAL(illegal));
  sdram_host_end sdram_host_end_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .LINK(sdram_link_if_inst.host), .CL3(cl3), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_BANK(req_bank),
    .REQ_ADDR(req_addr), .WR_DATA(wr_data), .WR_TAKE(wr_take),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .POWER(host_power));
  sdram_link_asserts sdram_link_asserts_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .CL3(cl3), .cs_n(sdram_link_if_inst.cs_n),
    .ras_n(sdram_link_if_inst.ras_n), .cas_n(sdram_link_if_inst.cas_n),
    .we_n(sdram_link_if_inst.we_n), .cke(sdram_link_if_inst.cke),
    .dqm(sdram_link_if_inst.dqm), .h_dq_oe(sdram_link_if_inst.h_dq_oe),
    .d_dq_oe(sdram_link_if_inst.d_dq_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data only depends on address, so no cut read is ever issued
  task automatic req(input op_t op, input logic [1:0] b, input logic [11:0] a);
    int n;
    req_op = op;
    req_bank = b;
    req_addr = a;
    req_valid = 1'b1;
    #1;
    for (n = 0; n < 300 && req_ready !== 1'b1; n++) begin
      @(negedge CLK);
      #1;
    end
    if (n == 300) begin
      err_count++;
      tally_and_finish();
    end
    if (op == OP_READ)
      for (n = 0; n < 4; n++)
        rq.push_back({b, 6'h15, a[7:2], a[1:0] + n[1:0]});
    @(negedge CLK);
    req_valid = 1'b0;
    // Idle edge so valid is never set twice in one step
    @(negedge CLK);
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 60 && rq.size() + wq.size() > 0; n++) @(negedge CLK);
    if (rq.size() + wq.size() > 0) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // ****
  // Monitors
  // ****
  always @(negedge CLK) wr_data <= 16'($urandom);
  always @(posedge CLK) begin
    if (wr_take === 1'b1) wq.push_back(wr_data);
    if (rd_valid === 1'b1) begin
      if (rq.size() == 0) chk(16'h0001, 16'h0000);
      else chk(rd_data, rq.pop_front());
    end
    if (mem_we === 1'b1) begin
      if (wq.size() == 0) chk(16'h0001, 16'h0000);
      else chk(mem_wdata, wq.pop_front());
    end
    if (illegal !== 1'b0) chk(16'h0001, 16'h0000);
  end
  initial begin
    void'($urandom(65));
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    SYS_RST = 0;
    for (int i = 0; i < 2; i++) begin
      logic [11:0] a;
      cl3 = i[0];
      a = 12'($urandom) & 12'h3ff;
      req(OP_ACT, 2'h0, a);
      req(OP_ACT, 2'h1, ~a & 12'h3ff);
      req(OP_WRITE, 2'h0, a | 12'h400);
      req(OP_READ, 2'h1, a);
      drain();
      req(OP_READ, 2'h1, a | 12'h400);
      drain();
      req(OP_ACT, 2'h0, a);
      req(OP_ACT, 2'h1, a);
      req(OP_WRITE, 2'h0, a);
      req(OP_WRITE, 2'h1, a | 12'h400);
      req(OP_READ, 2'h0, a);
      drain();
      req(OP_PRE, 2'h0, a);
      req(OP_REFRESH, 2'h0, a);
      foreach (sl[k]) begin
        req(sl[k], 2'h0, a);
        repeat (3) @(negedge CLK);
        chk(16'(dev_power), 16'(pw[k]));
        chk(16'(host_power), 16'(pw[k]));
        req(OP_WAKE, 2'h0, a);
      end
    end
    drain();
    tally_and_finish();
  end
endmodule
